// *** clk_ctrl.sv ***
/*
 Main clock controller: core clock prescaler, clock output, time base
 counter with tick flag and interrupt, low-power mode handling, APB slave.
 Assumes divided_osc_clock is pclk itself, qualified by ce, and that the
 core signals wait/halt requests synchronous to pclk.
*/
`timescale 1ns/1ns
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      ce,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      wait_req,
    input  wire logic                      halt_req,
    input  wire logic                      auto_wake_sleep,
    input  wire logic                      cpu_irq_mask,
    input  wire logic                      halt_wake_pin,
    output logic                           core_clock_en,
    output logic                           clk_out_pin,
    output logic                           clk_out_oe_n,
    output logic                           tick_irq,
    output logic                           irq,
    output logic [1:0]                     power_mode
);
    import clk_ctrl_pkg::*;

    logic [7:0]          ccs_q;
    logic [IRQ_BITS-1:0] ists_q;
    logic [IRQ_BITS-1:0] ien_q;
    power_mode_t         pm_q;
    logic [PRE_W-1:0]    pre_q;
    logic                core_en_q;
    logic                clk_out_q;
    logic                oe_n_q;
    logic                tick_irq_q;
    logic                irq_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;
    logic                wake_s1_q;
    logic                wake_s2_q;
    logic [1:0]          tb_sel;

    clk_div_if tb_if ();

    // Halt wake comes from a pin: two flops before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end
        else if (ce)
        begin
            wake_s1_q <= halt_wake_pin;
            wake_s2_q <= wake_s1_q;
        end
    end

    // Bus decode
    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire rd      = acc && !pwrite;
    wire hit_ccs = (paddr == CCS_ADDR);
    wire hit_sts = (paddr == IRQ_STATUS_ADDR);
    wire hit_ien = (paddr == IRQ_ENABLE_ADDR);
    wire hit_clr = (paddr == IRQ_CLEAR_ADDR);
    wire mapped  = hit_ccs || hit_sts || hit_ien || hit_clr;
    // Registers are shut to the bus in any halt or timed sleep; bus access has no effect then
    wire frozen  = (pm_q == PM_HALT) || (pm_q == PM_TIMED_SLEEP);
    // Refusal is judged in the setup cycle so that pslverr comes from a flop
    wire refuse  = !mapped || frozen;
    wire reg_ok  = ce && !pslverr_q;

    // Time base counter
    assign tb_sel = ccs_q[BIT_TB_HI:BIT_TB_LO];
    assign tb_if.limit = (tb_sel == 2'b00) ? TB_DIV0 :
                         (tb_sel == 2'b01) ? TB_DIV1 :
                         (tb_sel == 2'b10) ? TB_DIV2 : TB_DIV3;
    assign tb_if.run     = (pm_q != PM_HALT);
    assign tb_if.restart = 1'b0;                 // Limit is sampled only at reload

    clk_div_counter u_tb
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .dv      (tb_if.div)
    );

    wire tick      = tb_if.expire;
    wire ccs_read  = reg_ok && rd && hit_ccs;
    // In timed sleep the flag still records the expiry so the wake is visible after
    wire flag_set  = tick && (pm_q != PM_HALT);
    wire irq_fire  = flag_set && ccs_q[BIT_TICK_IE] && !cpu_irq_mask;
    // A pending unmasked request wakes as well, not only a fresh expiry
    wire tick_req  = ccs_q[BIT_TICK_FLAG] && ccs_q[BIT_TICK_IE] && !cpu_irq_mask;

    // Control/status register: set beats read-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ccs_q <= CCS_RESET;
        else if (ce)
        begin
            if (reg_ok && wr && hit_ccs)
                ccs_q[7:1] <= pwdata[7:1];
            if (flag_set)
                ccs_q[BIT_TICK_FLAG] <= 1'b1;
            // Only a flag that the read returned is cleared, so a set in the setup cycle survives
            else if (ccs_read && prdata_q[BIT_TICK_FLAG])
                ccs_q[BIT_TICK_FLAG] <= 1'b0;
        end
    end

    // Sticky status, write-one-to-clear, event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ists_q <= IRQ_RESET;
            ien_q  <= IRQ_RESET;
        end
        else if (ce)
        begin
            if (reg_ok && wr && hit_ien)
                ien_q <= pwdata[IRQ_BITS-1:0];
            ists_q <= (ists_q & ~((reg_ok && wr && hit_clr) ? pwdata[IRQ_BITS-1:0] : IRQ_RESET))
                      | IRQ_BITS'(flag_set);
        end
    end

    // Power mode sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pm_q <= PM_RUN;
        else if (ce)
        begin
            case (pm_q)
                PM_RUN:
                begin
                    if (halt_req && ccs_q[BIT_TICK_IE] && !auto_wake_sleep)
                        pm_q <= PM_TIMED_SLEEP;
                    else if (halt_req)
                        pm_q <= PM_HALT;
                    else if (wait_req)
                        pm_q <= PM_WAIT;
                end
                PM_WAIT:
                begin
                    if (irq_fire || tick_req || wake_s2_q)
                        pm_q <= PM_RUN;
                end
                PM_HALT:
                begin
                    if (wake_s2_q)
                        pm_q <= PM_RUN;
                end
                PM_TIMED_SLEEP:
                begin
                    if (irq_fire || tick_req || wake_s2_q)
                        pm_q <= PM_RUN;
                end
                default:
                    pm_q <= PM_RUN;
            endcase
        end
    end

    // Core clock prescaler: enable pulse once per divide period in slow mode
    wire [PRE_W-1:0] pre_mask = PRE_W'((5'h02 << ccs_q[BIT_DIV_HI:BIT_DIV_LO]) - 5'h01);
    wire             pre_wrap = ((pre_q & pre_mask) == pre_mask);
    wire             slow     = ccs_q[BIT_SLOW];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q     <= '0;
            core_en_q <= 1'b0;
        end
        else if (ce)
        begin
            pre_q     <= pre_wrap ? '0 : PRE_W'(pre_q + 1'b1);
            // Core is gated in any halt or sleep
            core_en_q <= (pm_q == PM_RUN) && (!slow || pre_wrap);
        end
    end

    // Clock out: toggle gives a visible half-rate copy of the qualified oscillator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_out_q <= 1'b0;
            oe_n_q    <= 1'b1;
        end
        else if (ce)
        begin
            clk_out_q <= ccs_q[BIT_CLK_OUT] && !clk_out_q;
            oe_n_q    <= !ccs_q[BIT_CLK_OUT];
        end
    end

    // Read data and interrupt outputs
    wire [31:0] rd_mux = hit_ccs ? {24'h000000, ccs_q} :
                         hit_sts ? 32'(ists_q) :
                         hit_ien ? 32'(ien_q) : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q   <= 32'h00000000;
            pslverr_q  <= 1'b0;
            tick_irq_q <= 1'b0;
            irq_q      <= 1'b0;
        end
        else if (ce)
        begin
            prdata_q   <= (psel && !penable && !pwrite) ? rd_mux : prdata_q;
            pslverr_q  <= psel && !penable && refuse;
            tick_irq_q <= tick_req;
            irq_q      <= |(ists_q & ien_q);
        end
    end

    assign prdata        = prdata_q;
    assign pready        = 1'b1;
    assign pslverr       = pslverr_q;
    assign core_clock_en = core_en_q;
    assign clk_out_pin   = clk_out_q;
    assign clk_out_oe_n  = oe_n_q;
    assign tick_irq      = tick_irq_q;
    assign irq           = irq_q;
    assign power_mode    = pm_q;
endmodule

// *** clk_ctrl_assertions.sv ***
/*
 Port checks for clk_ctrl: clock out, mask, power modes, frozen bus.
 Assumes a bind onto clk_ctrl and the single pclk domain.
*/
`timescale 1ns/1ns
module clk_ctrl_assertions
    import clk_ctrl_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pslverr,
    input wire logic       wait_req,
    input wire logic       halt_req,
    input wire logic       auto_wake_sleep,
    input wire logic       cpu_irq_mask,
    input wire logic       halt_wake_pin,
    input wire logic       clk_out_pin,
    input wire logic       clk_out_oe_n,
    input wire logic       tick_irq,
    input wire logic [1:0] power_mode
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_halt_req;
        power_mode == PM_RUN && halt_req && auto_wake_sleep;
    endsequence
    // Five quiet cycles cover the two-flop wake synchroniser
    sequence s_no_wake;
        !halt_wake_pin [*5];
    endsequence
    a_pin_idle: assert property (clk_out_oe_n |-> !clk_out_pin)
        else $error("clock out pin high while released");
    a_mask_blocks: assert property (cpu_irq_mask && $past(cpu_irq_mask) |-> !tick_irq)
        else $error("tick interrupt raised while masked");
    a_halt_entry: assert property (s_halt_req |=> power_mode == PM_HALT)
        else $error("auto-wake halt not entered");
    a_halt_holds: assert property (s_no_wake ##0 power_mode == PM_HALT |=> power_mode == PM_HALT)
        else $error("halt left without wake pin");
    a_wait_entry: assert property (power_mode == PM_RUN && wait_req && !halt_req |=> power_mode == PM_WAIT)
        else $error("wait not entered");
    a_wait_wake: assert property (power_mode == PM_WAIT && tick_irq |-> ##[1:3] power_mode == PM_RUN)
        else $error("tick interrupt did not end wait");
    a_sleep_wake: assert property (power_mode == PM_TIMED_SLEEP && tick_irq |-> ##[1:3] power_mode == PM_RUN)
        else $error("tick interrupt did not end timed sleep");
    // Both halt codes have bit 1 set; the refusal follows the mode seen in the setup cycle
    a_frozen_bus: assert property (psel && penable && $past(power_mode[1]) |-> pslverr)
        else $error("access accepted while frozen");
endmodule

// *** clk_ctrl_pkg.sv ***
/*
 Constants for the main clock controller: register map, field positions,
 reset values, divider counts and low-power mode codes.
 Assumes nothing of its surroundings.
*/
package clk_ctrl_pkg;

    localparam int unsigned ADDR_W           = 8;
    // Printed offset 2E is not a multiple of four: it is an index
    localparam int unsigned CCS_INDEX        = 46;
    localparam logic [ADDR_W-1:0] CCS_ADDR   = 8'(CCS_INDEX * 4);
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'hC0;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 8'hC4;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR  = 8'hC8;

    localparam logic [7:0] CCS_RESET         = 8'h00;
    localparam int unsigned BIT_CLK_OUT      = 7;
    localparam int unsigned BIT_DIV_HI       = 6;
    localparam int unsigned BIT_DIV_LO       = 5;
    localparam int unsigned BIT_SLOW         = 4;
    localparam int unsigned BIT_TB_HI        = 3;
    localparam int unsigned BIT_TB_LO        = 2;
    localparam int unsigned BIT_TICK_IE      = 1;
    localparam int unsigned BIT_TICK_FLAG    = 0;

    // Interrupt status layout: bit 0 tick event
    localparam int unsigned IRQ_BITS         = 1;
    localparam logic [IRQ_BITS-1:0] IRQ_RESET = 1'h0;

    localparam int unsigned TB_W             = 18;
    localparam logic [TB_W-1:0] TB_DIV0      = 18'd16000;
    localparam logic [TB_W-1:0] TB_DIV1      = 18'd32000;
    localparam logic [TB_W-1:0] TB_DIV2      = 18'd80000;
    localparam logic [TB_W-1:0] TB_DIV3      = 18'd200000;

    localparam int unsigned PRE_W            = 4;

    typedef enum logic [1:0]
    {
        PM_RUN         = 2'b00,
        PM_WAIT        = 2'b01,
        PM_HALT        = 2'b10,
        PM_TIMED_SLEEP = 2'b11
    } power_mode_t;

endpackage

// *** clk_ctrl_test.sv ***
/*
 Directed bench for clk_ctrl over APB.
 Assumes package, model and checker are compiled first.
*/
`timescale 1ns/1ns
module clk_ctrl_test;
    import clk_ctrl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        wait_req, halt_req, auto_wake_sleep, cpu_irq_mask, halt_wake_pin;
    logic        core_clock_en, clk_out_pin, clk_out_oe_n, tick_irq, irq, do_halt, do_wait, ce;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  power_mode;
    int          fails, check_count, cyc, ticks, t0, t1, a, b;

    clk_ctrl uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wait_req, .halt_req, .auto_wake_sleep, .cpu_irq_mask, .halt_wake_pin,
        .core_clock_en, .clk_out_pin, .clk_out_oe_n, .tick_irq, .irq, .power_mode);
    core_model core (.pclk, .presetn, .do_halt, .do_wait, .tick_irq, .halt_req, .wait_req, .ticks);

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Whole run is about 48200 cycles
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cnt();
        a = 0;
        b = 0;
        repeat (32) @(posedge pclk);
        repeat (64)
        begin
            @(posedge pclk);
            a += int'(core_clock_en === 1'b1);
            b += int'(clk_out_pin === 1'b1);
        end
    endtask

    task automatic pulse(input logic h);
        do_halt <= h;
        do_wait <= !h;
        @(posedge pclk);
        do_halt <= 1'b0;
        do_wait <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {auto_wake_sleep, cpu_irq_mask, halt_wake_pin, do_halt, do_wait} = '0;
        ce = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t0 = cyc;
        @(posedge pclk);
        apb(0, CCS_ADDR, 0);
        chk(rd, 0);
        apb(0, 8'h00, 0);
        chk(err, 1);
        apb(1, IRQ_ENABLE_ADDR, 1);
        cpu_irq_mask <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            apb(1, CCS_ADDR, 32'h90 | (c << 5));
            cnt();
            chk(a, 64 >> (c + 1));
            chk(b, 32);
            chk(clk_out_oe_n, 0);
        end
        apb(1, CCS_ADDR, 32'h06);
        cnt();
        chk(a, 64);
        chk(b, 0);
        chk(clk_out_oe_n, 1);
        while (irq !== 1'b1)
            @(posedge pclk);
        t1 = cyc;
        chk((t1 - t0) inside {[16000:16004]}, 1);
        chk(tick_irq, 0);
        apb(0, CCS_ADDR, 0);
        chk(rd, 32'h07);
        apb(0, CCS_ADDR, 0);
        chk(rd, 32'h06);
        chk(irq, 1);
        apb(1, IRQ_CLEAR_ADDR, 1);
        apb(0, IRQ_STATUS_ADDR, 0);
        chk(rd, 0);
        chk(irq, 0);
        cpu_irq_mask <= 1'b0;
        pulse(1);
        chk(power_mode, PM_TIMED_SLEEP);
        apb(1, CCS_ADDR, 0);
        chk(err, 1);
        while (tick_irq !== 1'b1)
            @(posedge pclk);
        chk((cyc - t1) inside {[31998:32002]}, 1);
        repeat (4) @(posedge pclk);
        chk(power_mode, PM_RUN);
        cpu_irq_mask <= 1'b1;
        pulse(0);
        chk(power_mode, PM_WAIT);
        cpu_irq_mask <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(power_mode, PM_RUN);
        chk(ticks, 2);
        apb(0, CCS_ADDR, 0);
        chk(rd, 32'h07);
        auto_wake_sleep <= 1'b1;
        pulse(1);
        repeat (40) @(posedge pclk);
        chk(power_mode, PM_HALT);
        halt_wake_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(power_mode, PM_RUN);
        apb(1, CCS_ADDR, 32'h80);
        ce <= 1'b0;
        cnt();
        chk(b inside {0, 64}, 1);
        chk(clk_out_oe_n, 0);
        conclude();
    end
endmodule

bind clk_ctrl clk_ctrl_assertions chk_i (.*);

// *** clk_div_counter.sv ***
/*
 Reloadable down counter: pulses expire for one cycle every limit enabled
 cycles; the limit is taken only at reload, so a change lands next period.
 Assumes the limit is at least one.
*/
`timescale 1ns/1ns
module clk_div_counter
    import clk_ctrl_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  ce,
    clk_div_if.div     dv
);
    logic [TB_W-1:0] cnt_q;
    logic [TB_W-1:0] cnt_d;
    logic            last;

    assign last  = (cnt_q == '0);
    assign cnt_d = (dv.restart || last) ? TB_W'(dv.limit - 1'b1) : TB_W'(cnt_q - 1'b1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= TB_W'(TB_DIV0 - 1'b1);                 // Full default period, no tick at release
        else if (ce && (dv.run || dv.restart))
            cnt_q <= cnt_d;
    end

    assign dv.expire = ce && dv.run && !dv.restart && last;
endmodule

// *** clk_div_if.sv ***
/*
 Interface carrying the clock-divider controls between the top and its
 divider modules.
 Assumes one clock domain.
*/
`timescale 1ns/1ns
interface clk_div_if;
    import clk_ctrl_pkg::*;
    logic              run;
    logic              restart;
    logic [TB_W-1:0]   limit;
    logic              expire;

    modport ctrl (output run, output restart, output limit, input expire);
    modport div  (input run, input restart, input limit, output expire);
endinterface

// *** core_model.sv ***
/*
 Core model: turns bench requests into halt and wait strobes one cycle later
 and counts tick interrupt requests it is offered.
 Assumes requests change just after a rising edge.
*/
`timescale 1ns/1ns
module core_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic do_halt,
    input  wire logic do_wait,
    input  wire logic tick_irq,
    output logic      halt_req,
    output logic      wait_req,
    output int        ticks
);
    logic tick_q;
    // Registered so strobes never move on the sampling edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halt_req <= 1'b0;
            wait_req <= 1'b0;
            tick_q   <= 1'b0;
            ticks    <= 0;
        end
        else
        begin
            halt_req <= do_halt;
            wait_req <= do_wait;
            tick_q   <= tick_irq;
            // One request per rising edge, as an edge-sensitive controller sees it
            ticks    <= ticks + int'(tick_irq && !tick_q);
        end
    end
endmodule
